// >>> hdl/rmp_pkg.sv
`default_nettype none
// shared constants for reset and mirror park control
package rmp_pkg;
   // =====================================================
   // clock and timing
   localparam int unsigned CLK_MHZ = 125;                    // core clock rate
   localparam int unsigned FAST_PARK_US = 40;                // fast park time budget
   localparam int unsigned FAST_PARK_CYC = FAST_PARK_US * CLK_MHZ;  // longest, exact product
   localparam int unsigned NORM_PARK_MS = 20;                // normal park upper bound
   localparam int unsigned NORM_PARK_CYC = NORM_PARK_MS * 1000 * CLK_MHZ;
   localparam int unsigned REQ_HOLD_MS = 200;                // least level hold of request
   localparam int unsigned REQ_HOLD_CYC = REQ_HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned QUIET_MS = 500;                   // config bus quiet time
   localparam int unsigned QUIET_CYC = QUIET_MS * 1000 * CLK_MHZ;
   localparam int unsigned INIT_CYC_DEF = 64;                // self-configuration length
   localparam int unsigned CNT_W = 32;                       // timer width
   // =====================================================
   // pin group widths and reset values
   localparam int unsigned GP_W = 15;                        // general pins 19:05
   localparam logic [14:0] GP_RST = 15'h0000;                // general pins output level
   // =====================================================
   // controller states
   typedef enum logic [2:0] {
      RMP_ST_INIT,          // self-configuration running
      RMP_ST_WAIT_PARK,     // waiting for fast park input high
      RMP_ST_RUN,           // normal operation
      RMP_ST_NORM_PARK,     // slow mirror park
      RMP_ST_FAST_PARK,     // quick mirror park
      RMP_ST_PARKED         // mirrors parked, drive off
   } rmp_state_t;
endpackage
`default_nettype wire

// >>> hdl/rmp_timer.sv
`default_nettype none
// =====================================================
// down counter: load on start, done pulse at zero
module rmp_timer #(
   parameter int unsigned W = 32                     // counter width
) (
   input wire logic i_core_clk,                      // core clock
   input wire logic i_rst,                           // async reset, active high
   input wire logic i_start,                         // load and run
   input wire logic i_stop,                          // abandon count
   input wire logic [W-1:0] i_load,                  // cycles to count
   output logic o_busy,                              // counting
   output logic o_done                               // one-cycle pulse at end
);
   logic [W-1:0] cnt_ff;                             // remaining cycles
   logic busy_ff;                                    // running flag
   logic done_ff;                                    // end pulse
   // count process; start beats stop so a restart is never lost
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_ff <= '0;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         if (i_start) begin
            cnt_ff <= i_load;
            busy_ff <= 1'b1;
         end else if (i_stop) begin
            busy_ff <= 1'b0;
         end else if (busy_ff) begin
            if (cnt_ff <= W'(1)) begin
               busy_ff <= 1'b0;
               done_ff <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff - W'(1);
            end
         end
      end
   end
   assign o_busy = busy_ff;
   assign o_done = done_ff;
endmodule
`default_nettype wire

// >>> hdl/rmp_ctrl.sv
`default_nettype none
// Overview of operation
// - start self-configuration on reset rising edge
// - tri-state serial, sync and general pins
// - light select and drive enable low
// - no output active during reset
// - normal operation only with fast park high
// - normal park completes within 20 ms
// - unused bidirectional pins drive after reset
// - park request low parks; 200 ms levels
// - host interrupt shows init, tri-state in reset
module rmp_ctrl
   import rmp_pkg::*;
#(
   parameter int unsigned INIT_CYC = INIT_CYC_DEF,    // self-configuration cycles
   parameter int unsigned FAST_CYC = FAST_PARK_CYC,   // fast park cycles
   parameter int unsigned NORM_CYC = NORM_PARK_CYC,   // normal park cycles
   parameter int unsigned QUIET_CYCLES = QUIET_CYC,   // config bus quiet cycles
   parameter int unsigned HOLD_CYCLES = REQ_HOLD_CYC  // request level filter
) (
   input wire logic i_core_clk,                        // core clock 125 MHz
   input wire logic i_rst,                             // async reset, active high
   input wire logic i_power_on_reset_n,                // power-on reset pin, active low
   input wire logic i_fast_park_n,                     // fast park pin, active low
   input wire logic i_normal_park_request_n,           // normal park request, active low
   input wire logic i_io_supply_ok,                    // related I/O supply present
   input wire logic i_gp_unused_drive,                 // drive unused general pins
   input wire logic [rmp_pkg::GP_W-1:0] i_gp_out,      // general pin output values
   output logic o_serial_oe,                           // serial and select pins drive enable
   output logic o_sync_oe,                             // sync outputs drive enable
   output logic [rmp_pkg::GP_W-1:0] o_gp_oe,           // general pins drive enable
   output logic [rmp_pkg::GP_W-1:0] o_gp_o,            // general pins output level
   output logic o_light_source_select_1,               // light source select
   output logic o_mirror_drive_enable_n,               // mirror drive enable, high while driving
   output logic o_host_irq_o,                          // host interrupt level
   output logic o_host_irq_oe,                         // host interrupt drive enable
   output logic o_config_bus_open,                     // config bus may be used
   output logic o_mirrors_parked,                      // mirrors in park
   output logic o_running                              // normal operation
);
   import rmp_pkg::*;

   // =====================================================
   // input edge tracking
   logic por_d_ff;                 // last reset pin level
   logic prq_d_ff;                 // last park request level
   logic por_rise;                 // reset pin released this cycle
   logic in_por;                   // reset pin asserted
   assign in_por = ~i_power_on_reset_n;
   assign por_rise = i_power_on_reset_n & ~por_d_ff;

   // reset pin history cleared low so a high pin at reset release counts; request history cleared high
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         por_d_ff <= 1'b0;
         prq_d_ff <= 1'b1;
      end else begin
         por_d_ff <= i_power_on_reset_n;
         prq_d_ff <= i_normal_park_request_n;
      end
   end

   // =====================================================
   // timers
   rmp_state_t st_ff;              // controller state
   rmp_state_t nxt_st;             // next state
   logic ph_start;                 // phase timer start
   logic [CNT_W-1:0] ph_load;      // phase timer length
   logic ph_done;                  // phase timer end
   logic q_start;                  // quiet timer start
   logic q_done;                   // quiet timer end
   logic quiet_ok_ff;              // quiet period elapsed

   rmp_timer #(.W(CNT_W)) u_phase (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_start(ph_start),
      .i_stop(in_por),
      .i_load(ph_load),
      .o_busy(),
      .o_done(ph_done)
   );

   // quiet period restarts whenever either pin is low
   assign q_start = in_por | ~i_fast_park_n;
   rmp_timer #(.W(CNT_W)) u_quiet (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_start(q_start),
      .i_stop(1'b0),
      .i_load(CNT_W'(QUIET_CYCLES)),
      .o_busy(),
      .o_done(q_done)
   );

   // quiet flag: drop on any reset or fast park, set at timer end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         quiet_ok_ff <= 1'b0;
      end else if (q_start) begin
         quiet_ok_ff <= 1'b0;
      end else if (q_done) begin
         quiet_ok_ff <= 1'b1;
      end
   end

   // =====================================================
   // request level filter: level must hold before it is obeyed
   logic [CNT_W-1:0] hold_ff;      // cycles since last request edge
   logic req_low_ff;               // filtered park request
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         hold_ff <= '0;
         req_low_ff <= 1'b0;
      end else if (i_normal_park_request_n != prq_d_ff) begin
         hold_ff <= '0;
      end else if (hold_ff < CNT_W'(HOLD_CYCLES)) begin
         hold_ff <= hold_ff + CNT_W'(1);
      end else begin
         req_low_ff <= ~i_normal_park_request_n;
      end
   end

   // =====================================================
   // state machine; reset pin forces init from any state
   always_comb begin
      nxt_st = st_ff;
      ph_start = 1'b0;
      ph_load = '0;
      if (in_por) begin
         nxt_st = RMP_ST_INIT;
      end else begin
         case (st_ff)
            RMP_ST_INIT: begin
               if (por_rise) begin
                  ph_start = 1'b1;
                  ph_load = CNT_W'(INIT_CYC);
               end else if (ph_done) begin
                  nxt_st = RMP_ST_WAIT_PARK;
               end
            end
            RMP_ST_WAIT_PARK: begin
               if (i_fast_park_n) begin
                  nxt_st = RMP_ST_RUN;
               end
            end
            RMP_ST_RUN: begin
               if (!i_fast_park_n) begin
                  nxt_st = RMP_ST_FAST_PARK;
                  ph_start = 1'b1;
                  ph_load = CNT_W'(FAST_CYC);
               end else if (req_low_ff) begin
                  nxt_st = RMP_ST_NORM_PARK;
                  ph_start = 1'b1;
                  ph_load = CNT_W'(NORM_CYC);
               end
            end
            RMP_ST_NORM_PARK: begin
               if (!i_fast_park_n) begin
                  nxt_st = RMP_ST_FAST_PARK;
                  ph_start = 1'b1;
                  ph_load = CNT_W'(FAST_CYC);
               end else if (ph_done) begin
                  nxt_st = RMP_ST_PARKED;
               end
            end
            RMP_ST_FAST_PARK: begin
               if (ph_done) begin
                  nxt_st = RMP_ST_PARKED;
               end
            end
            RMP_ST_PARKED: begin
               // leave park only with fast park high and request released
               if (i_fast_park_n && !req_low_ff) begin
                  nxt_st = RMP_ST_RUN;
               end
            end
            default: begin
               nxt_st = RMP_ST_INIT;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= RMP_ST_INIT;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // =====================================================
   // output registers; computed from next state so pins follow reset pin
   // in the same edge rather than a cycle late
   logic nxt_run;                  // next normal operation
   assign nxt_run = (nxt_st == RMP_ST_RUN) & ~in_por;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_serial_oe <= 1'b0;
         o_sync_oe <= 1'b0;
         o_gp_oe <= GP_RST;
         o_gp_o <= GP_RST;
      end else begin
         o_serial_oe <= ~in_por;
         o_sync_oe <= ~in_por;
         // unused general pins drive out after release only with i_gp_unused_drive high, so those inputs do not float
         o_gp_oe <= (in_por || !i_gp_unused_drive) ? GP_RST : ~GP_RST;
         o_gp_o <= in_por ? GP_RST : i_gp_out;
      end
   end

   // light source and mirror drive, low during reset with supply present
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_light_source_select_1 <= 1'b0;
         o_mirror_drive_enable_n <= 1'b0;
      end else begin
         o_light_source_select_1 <= nxt_run & i_io_supply_ok;
         // drive enable is held low (inactive reset of mirrors) in reset, without supply, and in init and parked states
         o_mirror_drive_enable_n <= ~in_por & i_io_supply_ok
                                    & (nxt_st != RMP_ST_PARKED)
                                    & (nxt_st != RMP_ST_INIT);
      end
   end

   // host interrupt: high while auto-init runs, falls when done
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_host_irq_o <= 1'b0;
         o_host_irq_oe <= 1'b0;
      end else begin
         o_host_irq_oe <= ~in_por;
         o_host_irq_o <= ~in_por & (nxt_st == RMP_ST_INIT);
      end
   end

   // status outputs
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_config_bus_open <= 1'b0;
         o_mirrors_parked <= 1'b0;
         o_running <= 1'b0;
      end else begin
         o_config_bus_open <= quiet_ok_ff & ~q_start & ~in_por;
         o_mirrors_parked <= ~in_por & (nxt_st == RMP_ST_PARKED);
         o_running <= nxt_run;
      end
   end
endmodule
`default_nettype wire

// >>> verification/rmp_ctrl_chk.sv
`default_nettype none
// =====================================================
// port checker for reset and park control
module rmp_ctrl_chk #(
   parameter int unsigned INIT_CYC = 8,    // init length
   parameter int unsigned FAST_CYC = 20,   // fast park length
   parameter int unsigned NORM_CYC = 50,   // normal park length
   parameter int unsigned HOLD_CYCLES = 10 // request filter
) (
   input wire logic i_core_clk,                    // clock
   input wire logic i_rst,                         // async reset
   input wire logic i_power_on_reset_n,            // reset pin
   input wire logic i_fast_park_n,                 // fast park pin
   input wire logic i_normal_park_request_n,       // park request
   input wire logic i_io_supply_ok,                // io supply
   input wire logic o_serial_oe,                   // serial enable
   input wire logic o_sync_oe,                     // sync enable
   input wire logic [rmp_pkg::GP_W-1:0] o_gp_oe,   // general enables
   input wire logic o_light_source_select_1,       // light select
   input wire logic o_mirror_drive_enable_n,       // drive enable
   input wire logic o_host_irq_o,                  // irq level
   input wire logic o_host_irq_oe,                 // irq enable
   input wire logic o_config_bus_open,             // quiet over
   input wire logic o_mirrors_parked,              // parked
   input wire logic o_running                      // running
);
   timeunit 1ns;
   timeprecision 1ps;
   import rmp_pkg::*;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // margins cover the timer load and the output register
   localparam int FAST_MAX = FAST_CYC + 4;
   localparam int NORM_MAX = NORM_CYC + 5;
   int unsigned irq_cnt_ff; // cycles irq level high
   int unsigned req_cnt_ff; // cycles request low
   // =====================================================
   // helper counters
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_cnt_ff <= 0;
      end else begin
         irq_cnt_ff <= o_host_irq_o ? irq_cnt_ff + 1 : 0;
      end
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         req_cnt_ff <= 0;
      end else begin
         req_cnt_ff <= i_normal_park_request_n ? 0 : req_cnt_ff + 1;
      end
   end
   // =====================================================
   // park steps
   sequence s_fast_hit;
      $fell(i_fast_park_n) && i_power_on_reset_n && o_host_irq_oe && !o_host_irq_o
         && !o_mirrors_parked;
   endsequence
   sequence s_norm_go;
      $fell(o_running) && i_power_on_reset_n && i_fast_park_n && !i_normal_park_request_n;
   endsequence
   chk_pins_float: assert property (
      !i_power_on_reset_n |=> !o_serial_oe && !o_sync_oe && (o_gp_oe == '0))
      else $error("pins driven in power-on reset");
   chk_low_held: assert property (
      !i_power_on_reset_n && i_io_supply_ok |=> !o_light_source_select_1
         && !o_mirror_drive_enable_n) else $error("light or drive enable high in reset");
   chk_none_active: assert property (
      !i_power_on_reset_n |=> !o_running && !o_config_bus_open)
      else $error("active output in reset");
   chk_irq_float: assert property (
      !i_power_on_reset_n |=> !o_host_irq_oe) else $error("irq driven in reset");
   chk_init_start: assert property (
      $rose(i_power_on_reset_n) |=> o_host_irq_o && o_host_irq_oe)
      else $error("init not started");
   chk_init_len: assert property (
      $fell(o_host_irq_o) && i_power_on_reset_n |-> irq_cnt_ff >= INIT_CYC
         && irq_cnt_ff <= INIT_CYC + 2) else $error("init length wrong");
   chk_park_blocks: assert property (
      !i_fast_park_n |=> !o_running) else $error("running with fast park low");
   chk_light_run: assert property (
      o_light_source_select_1 |-> o_running && $past(i_fast_park_n) && $past(i_io_supply_ok))
      else $error("light outside run");
   chk_req_filter: assert property (
      req_cnt_ff > 0 && req_cnt_ff < HOLD_CYCLES - 1 && i_power_on_reset_n && i_fast_park_n
         && o_running |=> o_running) else $error("short request left run");
   chk_norm_done: assert property (
      s_norm_go |-> ##[1:NORM_MAX] o_mirrors_parked) else $error("normal park too long");
   chk_fast_done: assert property (
      s_fast_hit |-> ##[1:FAST_MAX] o_mirrors_parked) else $error("fast park too long");
endmodule
bind rmp_ctrl rmp_ctrl_chk #(.INIT_CYC(INIT_CYC), .FAST_CYC(FAST_CYC), .NORM_CYC(NORM_CYC),
   .HOLD_CYCLES(HOLD_CYCLES)) u_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
   .i_power_on_reset_n(i_power_on_reset_n), .i_fast_park_n(i_fast_park_n),
   .i_normal_park_request_n(i_normal_park_request_n), .i_io_supply_ok(i_io_supply_ok),
   .o_serial_oe(o_serial_oe), .o_sync_oe(o_sync_oe), .o_gp_oe(o_gp_oe),
   .o_light_source_select_1(o_light_source_select_1), .o_host_irq_o(o_host_irq_o),
   .o_mirror_drive_enable_n(o_mirror_drive_enable_n), .o_host_irq_oe(o_host_irq_oe),
   .o_config_bus_open(o_config_bus_open), .o_mirrors_parked(o_mirrors_parked),
   .o_running(o_running));
`default_nettype wire

// >>> verification/rmp_pmic_host.sv
`default_nettype none
// =====================================================
// power chip and host model, drives on falling edge
module rmp_pmic_host #(
   parameter int unsigned FAST_CYC = 20 // fast park length
) (
   input wire logic i_core_clk,          // clock
   output logic o_power_on_reset_n,      // reset pin
   output logic o_fast_park_n,           // fast park pin
   output logic o_normal_park_request_n  // park request
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned park_low_cnt = 0; // cycles fast park held low
   initial begin
      o_power_on_reset_n = 1'b0;
      o_fast_park_n = 1'b1;
      o_normal_park_request_n = 1'b1;
   end
   always @(posedge i_core_clk) begin
      park_low_cnt <= o_fast_park_n ? 0 : park_low_cnt + 1;
   end
   // supplies and clocks taken as stable here; lvl 0 breaks the order on purpose
   task automatic power_on(input logic lvl);
      o_fast_park_n = lvl; // park line up before reset release
      @(negedge i_core_clk);
      o_power_on_reset_n = 1'b1;
   endtask
   // only on imminent loss, never as a normal stop
   task automatic power_loss();
      o_fast_park_n = 1'b0;
   endtask
   // supplies drop only after the fast park budget has run out
   task automatic power_off();
      while (park_low_cnt < FAST_CYC + 8) @(negedge i_core_clk);
      o_power_on_reset_n = 1'b0;
   endtask
   // reset stays high through a normal park
   task automatic park_request(input logic lvl, input int unsigned cyc);
      o_normal_park_request_n = lvl;
      repeat (cyc) @(negedge i_core_clk);
   endtask
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`default_nettype none
// =====================================================
// bench: notes queued by driver, compared by monitor
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rmp_pkg::*;
   localparam int unsigned T_INIT = 8, T_FAST = 20, T_NORM = 50, T_QUIET = 100, T_HOLD = 10;
   localparam int unsigned LIMIT = 2000; // ample for all scenarios
   // snapshot order: gp match, serial, sync, gp all on, light, drive, irq, irq en, bus,
   // parked, running
   localparam logic [10:0] M_RST = 11'h3ED, V_INIT = 11'h318, M_INIT = 11'h35F;
   localparam logic [10:0] M_BLK = 11'h041, V_RUN = 11'h7E9, M_RUN = 11'h7FF;
   localparam logic [10:0] V_PRK = 11'h00A, M_PRK = 11'h06B, M_BUS = 11'h004;
   typedef struct packed {logic [10:0] e; logic [10:0] m;} rmp_note_t;
   logic core_clk, rst, io_ok, gp_drive, chk_req, por_n, park_n, req_n;
   logic serial_oe, sync_oe, light, den_n, irq_o, irq_oe, bus_open, parked, running;
   logic [GP_W-1:0] gp_out, gp_oe, gp_o;
   logic [7:0] rnd_ff = 8'h42; // random source state
   rmp_note_t note_q[$];
   rmp_note_t n;
   int errors = 0, checks = 0, cyc = 0, t0;
   rmp_ctrl #(.INIT_CYC(T_INIT), .FAST_CYC(T_FAST), .NORM_CYC(T_NORM), .QUIET_CYCLES(T_QUIET),
      .HOLD_CYCLES(T_HOLD)) dut (.i_core_clk(core_clk), .i_rst(rst),
      .i_power_on_reset_n(por_n), .i_fast_park_n(park_n), .i_normal_park_request_n(req_n),
      .i_io_supply_ok(io_ok), .i_gp_unused_drive(gp_drive), .i_gp_out(gp_out),
      .o_serial_oe(serial_oe), .o_sync_oe(sync_oe), .o_gp_oe(gp_oe), .o_gp_o(gp_o),
      .o_light_source_select_1(light), .o_mirror_drive_enable_n(den_n), .o_host_irq_o(irq_o),
      .o_host_irq_oe(irq_oe), .o_config_bus_open(bus_open), .o_mirrors_parked(parked),
      .o_running(running));
   rmp_pmic_host #(.FAST_CYC(T_FAST)) pmic (.i_core_clk(core_clk), .o_power_on_reset_n(por_n),
      .o_fast_park_n(park_n), .o_normal_park_request_n(req_n));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   function automatic logic [10:0] snap();
      return {gp_o === gp_out, serial_oe, sync_oe, gp_oe === {GP_W{1'b1}}, light, den_n,
         irq_o, irq_oe, bus_open, parked, running};
   endfunction
   // next state of the 8-bit random source, maximal length taps
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic new_gp();
      rnd_ff = lfsr_next(rnd_ff);
      gp_out = {rnd_ff, rnd_ff[6:0]};
   endtask
   // note the expectation; the monitor compares on the next falling edge
   task automatic expect_out(input logic [10:0] e, input logic [10:0] m);
      note_q.push_back('{e, m});
      chk_req <= 1'b1;
      @(negedge core_clk);
      chk_req <= 1'b0;
      @(negedge core_clk);
   endtask
   // bounded wait for one snapshot bit
   task automatic wait_until(input int b, input logic v, input int lim);
      logic [10:0] s;
      int k;
      k = 0;
      s = snap();
      while (s[b] !== v && k < lim) begin
         @(negedge core_clk);
         s = snap();
         k++;
      end
      if (k >= lim) begin
         errors++;
         $display("ERROR %0t: bit %0d never reached %b", $time, b, v);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // monitor: outputs settled at the falling edge
   always @(negedge core_clk) begin
      if (chk_req === 1'b1) begin
         n = note_q.pop_front();
         checks++;
         if (((snap() ^ n.e) & n.m) !== 11'h000) begin
            errors++;
            $display("ERROR %0t: got %h want %h mask %h", $time, snap(), n.e, n.m);
         end
      end
   end
   // hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         $display("ERROR %0t: run too long", $time);
         report_and_stop();
      end
   end
   initial begin
      rst = 1'b1;
      io_ok = 1'b1;
      gp_drive = 1'b1;
      chk_req = 1'b0;
      gp_out = '0;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      @(negedge core_clk);
      expect_out(11'h000, M_RST);
      new_gp();
      pmic.power_on(1'b0);
      @(negedge core_clk);
      expect_out(V_INIT, M_INIT);
      repeat (T_INIT + 6) @(negedge core_clk);
      expect_out(11'h000, M_BLK);
      pmic.power_on(1'b1);
      t0 = cyc;
      wait_until(0, 1'b1, 6);
      expect_out(V_RUN, M_RUN);
      while (cyc < t0 + T_QUIET - 5) @(negedge core_clk);
      expect_out(11'h000, M_BUS);
      wait_until(2, 1'b1, 20);
      expect_out(V_RUN | M_BUS, M_RUN);
      pmic.park_request(1'b0, T_HOLD / 2);
      pmic.park_request(1'b1, T_HOLD + 4);
      expect_out(V_RUN | M_BUS, M_RUN);
      pmic.park_request(1'b0, T_HOLD + 2);
      wait_until(1, 1'b1, T_NORM + 10);
      expect_out(V_PRK, M_PRK);
      pmic.park_request(1'b1, T_HOLD + 2);
      wait_until(0, 1'b1, 10);
      expect_out(V_RUN | M_BUS, M_RUN);
      pmic.park_request(1'b0, T_HOLD + 6);
      pmic.power_loss();
      wait_until(1, 1'b1, T_FAST + 8);
      expect_out(V_PRK, M_PRK);
      pmic.power_off();
      expect_out(11'h000, M_RST);
      pmic.park_request(1'b1, 2);
      new_gp();
      pmic.power_on(1'b1);
      wait_until(0, 1'b1, T_INIT + 10);
      expect_out(V_RUN, M_RUN);
      // supply gone and general pins left undriven while running
      io_ok = 1'b0;
      gp_drive = 1'b0;
      expect_out(V_RUN & ~11'h0E0, M_RUN);
      io_ok = 1'b1;
      gp_drive = 1'b1;
      pmic.power_loss();
      wait_until(1, 1'b1, T_FAST + 8);
      expect_out(V_PRK, M_PRK);
      pmic.power_off();
      expect_out(11'h000, M_RST);
      report_and_stop();
   end
endmodule
`default_nettype wire
